//--- rtl/spad_top.sv
// serial network port with external address detection, apb registers
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`default_nettype none
// Summary of operation
// - serial receive data is sampled on receive clock rises while valid high
// - transmit activity is paced by the transceiver transmit clock rises
// - transmit sends preamble, start delimiter, payload and optional check
// - transmit data counts only while transmit valid is high
// - frame rejected if internal match fails or external reject is low
// - byte strobe rises after second one of start delimiter, four bits
// - byte strobe then toggles every four bits, rising on byte starts
// - decoded serial output carries the whole received stream, preamble included
// - nibble mode strobe rises one receive clock after delimiter seen
// - nibble mode strobe toggles every nibble, marking each byte start
// - byte strobe is inactive outside frame reception
// - serial mode drives decoded data synchronous to decoded clock output
// - nibble port selected: decoded data and clock outputs stay static
// - detect and tagging on, serial: tag from nibble data0 and valid pins
// - detect and tagging on, nibble: tag from decoded data and clock pins
// - collision input flags collisions in serial mode only, pin shared with nibble collision
// - serial transmit pins double as nibble data0, enable and clock
// - automatic selection picks nibble port when management line rests high
// - serial port active only with automatic selection off, chosen by hand
module spad_top
    import spad_pkg::*;
(
    input wire logic core_clk, // core clock
    input wire logic srst, // synchronous reset
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic serial_transmit_clock, // transceiver tx clock
    output logic serial_transmit_data, // tx bit stream
    output logic serial_transmit_valid, // tx enable
    input wire logic serial_receive_clock, // rx clock
    input wire logic serial_receive_data, // rx data, nibble rx error
    input wire logic serial_receive_valid, // rx enable
    input wire logic serial_collision_in, // collision
    input wire logic external_reject_n, // external reject
    output logic frame_byte_strobe, // byte delimiter strobe
    input wire logic decoded_rx_serial_in, // decoded data pin in
    output logic decoded_rx_serial_out, // decoded data pin out
    output logic decoded_rx_serial_oe, // decoded data pin drive
    input wire logic decoded_rx_clock_in, // decoded clock pin in
    output logic decoded_rx_clock_out, // decoded clock pin out
    output logic decoded_rx_clock_oe, // decoded clock pin drive
    input wire logic nibble_rx_valid, // nibble rx valid
    input wire logic [3:0] nibble_rx_data, // nibble rx data
    input wire logic mdio_in // management data level
);
    logic [13:0] pins_s;
    logic txc_d, rxc_d;
    logic [31:0] ctrl, sta_lo, sta_hi, rx_tag;
    logic [15:0] acc_cnt, rej_cnt;
    logic coll_st, under_st, acc_st, rej_st;
    logic [7:0] hold_byte;
    logic hold_last, hold_full;
    spad_rx_t rx_state;
    logic rx_prev, sta_hit, bc_hit, ext_rej;
    logic [2:0] rx_cnt, byte_idx;
    logic [7:0] rx_byte;
    logic [15:0] tag_shift;
    spad_tx_t tx_state;
    logic [7:0] tx_sh;
    logic [2:0] tx_bit, tx_pre_n;
    logic [4:0] tx_fcs_n;
    logic tx_last, tx_underrun;
    logic [31:0] crc;
    logic [31:0] status_word;

    function automatic logic [31:0] crc_step(input logic [31:0] c,
                                             input logic b);
        crc_step = {1'b0, c[31:1]} ^ ((c[0] ^ b) ? CRC_POLY : 32'h0);
    endfunction

    function automatic logic [7:0] sta_byte(input logic [47:0] a,
                                            input logic [2:0] i);
        sta_byte = a[i*8 +: 8];
    endfunction

    // every pin level crosses through two flops
    spad_sync #(.W(14)) u_sync (
        .core_clk(core_clk),
        .srst(srst),
        .async_in({serial_transmit_clock, serial_receive_clock,
                   serial_receive_data, serial_receive_valid,
                   serial_collision_in, external_reject_n, mdio_in,
                   nibble_rx_valid, nibble_rx_data,
                   decoded_rx_serial_in, decoded_rx_clock_in}),
        .sync_out(pins_s)
    );
    wire txc_s = pins_s[13];
    wire rxc_s = pins_s[12];
    wire rxd_s = pins_s[11];
    wire serial_receive_valid_s = pins_s[10];
    wire col_s = pins_s[9];
    wire ear_s = pins_s[8];
    wire mdio_s = pins_s[7];
    wire ndv_s = pins_s[6];
    wire [3:0] nrxd_s = pins_s[5:2];
    wire srd_in_s = pins_s[1];
    wire decoded_rx_clock_out_in_s = pins_s[0];

    // port selection
    wire auto_sel = ctrl[CB_AUTO];
    wire man_serial = ctrl[CB_SERIAL];
    wire ext_det = ctrl[CB_EXTDET];
    wire tag_on = ext_det & ctrl[CB_TAGGING];
    wire serial_act = ~auto_sel & man_serial;
    wire nibble_act = auto_sel ? mdio_s : ~man_serial;

    // edge finders on the synchronised clock levels
    always_ff @(posedge core_clk) begin
        if (srst) begin
            txc_d <= 1'b0;
            rxc_d <= 1'b0;
        end else begin
            txc_d <= txc_s;
            rxc_d <= rxc_s;
        end
    end
    wire tx_edge = txc_s & ~txc_d;
    wire rx_edge = rxc_s & ~rxc_d;

    // apb decode; one wait state so every answer comes from a flop
    wire apb_acc = psel & penable & ~pready;
    wire wr_en = psel & penable & pready & pwrite;
    wire hit_ctrl = paddr == ADDR_CTRL;
    wire hit_stat = paddr == ADDR_STATUS;
    wire hit_txd = paddr == ADDR_TXDATA;
    wire hit_lo = paddr == ADDR_STA_LO;
    wire hit_hi = paddr == ADDR_STA_HI;
    wire hit_tag = paddr == ADDR_TAG;
    wire hit_cnt = paddr == ADDR_COUNT;
    wire mapped = hit_ctrl | hit_stat | hit_txd | hit_lo | hit_hi |
                  hit_tag | hit_cnt;
    wire [31:0] rd_mux = hit_ctrl ? ctrl :
                         hit_stat ? status_word :
                         hit_lo ? sta_lo :
                         hit_hi ? sta_hi :
                         hit_tag ? rx_tag :
                         hit_cnt ? {rej_cnt, acc_cnt} : 32'h0;
    wire [31:0] st_clr = (wr_en & hit_stat) ? pwdata : 32'h0;

    // status word assembled by field name
    always_comb begin
        status_word = 32'h0;
        status_word[SB_TXBUSY] = tx_state != TX_IDLE;
        status_word[SB_HOLD] = hold_full;
        status_word[SB_SERIAL] = serial_act;
        status_word[SB_NIBBLE] = nibble_act;
        status_word[SB_INFRAME] = rx_state == RX_DATA;
        status_word[SB_COLL] = coll_st;
        status_word[SB_UNDER] = under_st;
        status_word[SB_ACC] = acc_st;
        status_word[SB_REJ] = rej_st;
    end

    // apb answer flops
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready <= apb_acc;
            prdata <= (apb_acc & ~pwrite) ? rd_mux : 32'h0;
            pslverr <= apb_acc & ~mapped;
        end
    end

    // software written configuration
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ctrl <= CTRL_RESET;
            sta_lo <= 32'h0;
            sta_hi <= 32'h0;
        end else if (wr_en) begin
            if (hit_ctrl) ctrl <= pwdata & CTRL_MASK;
            if (hit_lo) sta_lo <= pwdata;
            if (hit_hi) sta_hi <= {16'h0, pwdata[15:0]};
        end
    end

    // receive side decode, shared by serial and nibble ports
    wire rx_act = serial_act ? serial_receive_valid_s : (nibble_act & ndv_s);
    wire rx_step = rx_edge & rx_act;
    wire sfd_ser = serial_act & rxd_s & rx_prev;
    wire sfd_nib = nibble_act & ~rxd_s & (nrxd_s == SFD_NIB);
    wire [2:0] rx_inc = serial_act ? 3'h1 : 3'h4;
    wire [2:0] next_cnt = rx_cnt + rx_inc;
    wire [7:0] next_byte = serial_act ? {rxd_s, rx_byte[7:1]} :
                                        {nrxd_s, rx_byte[7:4]};
    wire data_step = rx_step & (rx_state == RX_DATA);
    wire byte_done = data_step & (next_cnt == 3'h0);
    wire commit = (rx_state == RX_DATA) & ~rx_act;
    wire reject_now = ~(sta_hit | bc_hit) | (byte_idx < ADDR_LEN) |
                      ext_rej | ~ear_s;
    wire [47:0] sta_addr = {sta_hi[15:0], sta_lo};

    // receive framing and byte strobe
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rx_state <= RX_IDLE;
            frame_byte_strobe <= 1'b0;
            rx_prev <= 1'b0;
            rx_cnt <= 3'h0;
        end else if (rx_state != RX_IDLE && !rx_act) begin
            rx_state <= RX_IDLE;
            frame_byte_strobe <= 1'b0;
        end else if (rx_step) begin
            unique case (rx_state)
                RX_IDLE: begin
                    rx_state <= RX_HUNT;
                    rx_prev <= 1'b0;
                end
                RX_HUNT: begin
                    rx_prev <= rxd_s;
                    if (sfd_ser) begin
                        rx_state <= RX_DATA;
                        frame_byte_strobe <= ext_det;
                        rx_cnt <= 3'h0;
                    end else if (sfd_nib) begin
                        rx_state <= RX_ARM;
                    end
                end
                RX_ARM: begin
                    rx_state <= RX_DATA;
                    frame_byte_strobe <= ext_det;
                    rx_cnt <= 3'h0;
                end
                RX_DATA: begin
                    rx_cnt <= next_cnt;
                    // high on first half of each byte
                    frame_byte_strobe <= ext_det & ~next_cnt[2];
                end
            endcase
        end
    end

    // byte assembly and address compare
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rx_byte <= 8'h0;
            byte_idx <= 3'h0;
            sta_hit <= 1'b1;
            bc_hit <= 1'b1;
            ext_rej <= 1'b0;
        end else if (rx_step && rx_state == RX_IDLE) begin
            byte_idx <= 3'h0;
            sta_hit <= 1'b1;
            bc_hit <= 1'b1;
            ext_rej <= 1'b0;
        end else begin
            if (rx_state != RX_IDLE && !ear_s) ext_rej <= 1'b1;
            if (data_step) rx_byte <= next_byte;
            if (byte_done && byte_idx < ADDR_LEN) begin
                byte_idx <= byte_idx + 3'h1;
                sta_hit <= sta_hit &
                           (next_byte == sta_byte(sta_addr, byte_idx));
                bc_hit <= bc_hit & (next_byte == BCAST_BYTE);
            end
        end
    end

    // frame tag capture; pins swap with the selected port
    // serial: nibble data0 and valid
    wire tag_d = nibble_act ? srd_in_s : nrxd_s[0];
    wire tag_e = nibble_act ? decoded_rx_clock_out_in_s : ndv_s;
    always_ff @(posedge core_clk) begin
        if (srst) begin
            tag_shift <= 16'h0;
            rx_tag <= 32'h0;
        end else if (rx_step && rx_state == RX_IDLE) begin
            tag_shift <= 16'h0;
        end else begin
            if (rx_edge && tag_on && tag_e) begin
                tag_shift <= {tag_shift[14:0], tag_d};
            end
            if (commit) rx_tag <= {16'h0, tag_shift};
        end
    end

    // frame counters and sticky flags, a set beats a clear
    always_ff @(posedge core_clk) begin
        if (srst) begin
            acc_cnt <= 16'h0;
            rej_cnt <= 16'h0;
            acc_st <= 1'b0;
            rej_st <= 1'b0;
            coll_st <= 1'b0;
            under_st <= 1'b0;
        end else begin
            if (commit && !reject_now) acc_cnt <= acc_cnt + 16'h1;
            if (commit && reject_now) rej_cnt <= rej_cnt + 16'h1;
            acc_st <= (acc_st & ~st_clr[SB_ACC]) | (commit & ~reject_now);
            rej_st <= (rej_st & ~st_clr[SB_REJ]) | (commit & reject_now);
            coll_st <= (coll_st & ~st_clr[SB_COLL]) | (col_s & serial_act);
            under_st <= (under_st & ~st_clr[SB_UNDER]) | tx_underrun;
        end
    end

    // decoded receive outputs; static in nibble mode, released only with tagging on
    always_ff @(posedge core_clk) begin
        if (srst) begin
            decoded_rx_serial_out <= 1'b0;
            decoded_rx_clock_out <= 1'b0;
            decoded_rx_serial_oe <= 1'b0;
            decoded_rx_clock_oe <= 1'b0;
        end else if (serial_act) begin
            decoded_rx_serial_oe <= 1'b1;
            decoded_rx_clock_oe <= 1'b1;
            decoded_rx_clock_out <= rxc_d;
            if (rx_step) decoded_rx_serial_out <= rxd_s;
        end else begin
            decoded_rx_serial_out <= 1'b0;
            decoded_rx_clock_out <= 1'b0;
            decoded_rx_serial_oe <= ~(nibble_act & tag_on);
            decoded_rx_clock_oe <= ~(nibble_act & tag_on);
        end
    end

    // transmit holding register, one byte deep, no queue behind it
    wire need_byte = tx_edge & (tx_bit == 3'h7) & ~col_s &
                     ((tx_state == TX_PRE && tx_pre_n == SFD_IDX) ||
                      (tx_state == TX_DATA && !tx_last));
    wire tx_load = need_byte & hold_full;
    assign tx_underrun = need_byte & ~hold_full;
    always_ff @(posedge core_clk) begin
        if (srst) begin
            hold_full <= 1'b0;
            hold_byte <= 8'h0;
            hold_last <= 1'b0;
        end else if (tx_load) begin
            hold_full <= 1'b0;
        end else if (wr_en && hit_txd && !hold_full) begin
            hold_full <= 1'b1;
            hold_byte <= pwdata[7:0];
            hold_last <= pwdata[TXD_LAST];
        end
    end

    // transmit shifter
    // paced by transmit clock rises
    wire tx_byte_end = tx_bit == 3'h7;
    wire [31:0] crc_next = crc_step(crc, tx_sh[0]);
    always_ff @(posedge core_clk) begin
        if (srst) begin
            tx_state <= TX_IDLE;
            serial_transmit_data <= 1'b0;
            serial_transmit_valid <= 1'b0;
            tx_sh <= 8'h0;
            tx_bit <= 3'h0;
            tx_pre_n <= 3'h0;
            tx_fcs_n <= 5'h0;
            tx_last <= 1'b0;
            crc <= CRC_INIT;
        end else if (tx_edge) begin
            if (tx_state == TX_IDLE || col_s) begin
                tx_state <= TX_IDLE;
                serial_transmit_valid <= 1'b0;
                serial_transmit_data <= 1'b0;
                if (tx_state == TX_IDLE && hold_full && serial_act) begin
                    tx_state <= TX_PRE;
                    tx_sh <= PRE_BYTE;
                    tx_bit <= 3'h0;
                    tx_pre_n <= 3'h0;
                    crc <= CRC_INIT;
                end
            end else begin
                // pin also nibble data bit 0
                serial_transmit_valid <= 1'b1;
                serial_transmit_data <= (tx_state == TX_FCS) ? ~crc[0] :
                                                               tx_sh[0];
                tx_bit <= tx_bit + 3'h1;
                tx_sh <= {1'b0, tx_sh[7:1]};
                if (tx_state == TX_DATA) crc <= crc_next;
                if (tx_state == TX_FCS) crc <= {1'b0, crc[31:1]};
                if (tx_state == TX_FCS) tx_fcs_n <= tx_fcs_n + 5'h1;
                if (tx_state == TX_FCS && tx_fcs_n == FCS_LAST) begin
                    tx_state <= TX_IDLE;
                end
                if (tx_byte_end && tx_state == TX_PRE) begin
                    tx_pre_n <= tx_pre_n + 3'h1;
                    tx_sh <= (tx_pre_n == PRE_LAST) ? SFD_BYTE : PRE_BYTE;
                end
                if (tx_byte_end && tx_state == TX_DATA && tx_last) begin
                    tx_state <= ctrl[CB_FCS] ? TX_FCS : TX_IDLE;
                    tx_fcs_n <= 5'h0;
                end
                if (tx_load) begin
                    tx_state <= TX_DATA;
                    tx_sh <= hold_byte;
                    tx_last <= hold_last;
                end
                if (tx_underrun) tx_state <= TX_IDLE;
            end
        end
    end

    // checks beside the logic they guard
    a_rx_sample_valid: assert property (@(posedge core_clk) disable iff (srst)
        data_step |-> serial_receive_valid_s | ndv_s)
        else $error("receive bit taken without valid");
    a_tx_on_clock: assert property (@(posedge core_clk) disable iff (srst)
        $changed(serial_transmit_valid) |-> $past(tx_edge))
        else $error("tx enable moved off a tx clock rise");
    a_tx_first_bit: assert property (@(posedge core_clk) disable iff (srst)
        $rose(serial_transmit_valid) |-> serial_transmit_data)
        else $error("preamble did not start with a one");
    a_tx_idle_zero: assert property (@(posedge core_clk) disable iff (srst)
        !serial_transmit_valid |-> !serial_transmit_data)
        else $error("tx data high while not valid");
    a_reject_ext: assert property (@(posedge core_clk) disable iff (srst)
        commit && !ear_s |=> rej_st && !$stable(rej_cnt))
        else $error("external reject did not discard frame");
    a_strobe_sfd: assert property (@(posedge core_clk) disable iff (srst)
        rx_step && rx_state == RX_HUNT && sfd_ser && ext_det
        |=> frame_byte_strobe && rx_state == RX_DATA)
        else $error("strobe missed start delimiter");
    a_strobe_fall: assert property (@(posedge core_clk) disable iff (srst)
        data_step && rx_act && rx_cnt == 3'h3 |=> !frame_byte_strobe)
        else $error("strobe not low after four bits");
    a_nibble_toggle: assert property (@(posedge core_clk) disable iff (srst)
        data_step && nibble_act && ext_det && rx_act
        |=> frame_byte_strobe != $past(frame_byte_strobe))
        else $error("nibble strobe did not toggle");
    a_strobe_idle: assert property (@(posedge core_clk) disable iff (srst)
        rx_state == RX_IDLE |-> !frame_byte_strobe)
        else $error("strobe active outside a frame");
    a_srd_static: assert property (@(posedge core_clk) disable iff (srst)
        !serial_act ##1 !serial_act |-> !decoded_rx_clock_out &&
        !decoded_rx_serial_out)
        else $error("decoded outputs moved in nibble mode");
    a_port_manual: assert property (@(posedge core_clk) disable iff (srst)
        serial_act |-> !auto_sel && !nibble_act)
        else $error("serial port active under auto select");
endmodule
`default_nettype wire

//--- rtl/spad_pkg.sv
// constants shared by the serial port and address detect block
`default_nettype none
package spad_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_TXDATA = 8'h08;
    localparam logic [7:0] ADDR_STA_LO = 8'h0C;
    localparam logic [7:0] ADDR_STA_HI = 8'h10;
    localparam logic [7:0] ADDR_TAG = 8'h14;
    localparam logic [7:0] ADDR_COUNT = 8'h18;
    // control fields
    localparam int CB_AUTO = 0;
    localparam int CB_SERIAL = 1;
    localparam int CB_FCS = 2;
    localparam int CB_EXTDET = 3;
    localparam int CB_TAGGING = 14;
    localparam logic [31:0] CTRL_RESET = 32'h00000005;
    localparam logic [31:0] CTRL_MASK = 32'h0000400F;
    // status fields and the transmit data last bit
    localparam int SB_TXBUSY = 0;
    localparam int SB_HOLD = 1;
    localparam int SB_SERIAL = 2;
    localparam int SB_NIBBLE = 3;
    localparam int SB_INFRAME = 4;
    localparam int SB_COLL = 8;
    localparam int SB_UNDER = 9;
    localparam int SB_ACC = 10;
    localparam int SB_REJ = 11;
    localparam int TXD_LAST = 8;
    // frame constants
    localparam logic [7:0] PRE_BYTE = 8'h55;
    localparam logic [7:0] SFD_BYTE = 8'hD5;
    localparam logic [7:0] BCAST_BYTE = 8'hFF;
    localparam logic [3:0] SFD_NIB = 4'hD;
    localparam logic [2:0] PRE_LAST = 3'h6;
    localparam logic [2:0] SFD_IDX = 3'h7;
    localparam logic [2:0] ADDR_LEN = 3'h6;
    localparam logic [4:0] FCS_LAST = 5'h1F;
    localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
    localparam logic [31:0] CRC_POLY = 32'hEDB88320;
    typedef enum logic [1:0] {RX_IDLE, RX_HUNT, RX_ARM, RX_DATA} spad_rx_t;
    typedef enum logic [1:0] {TX_IDLE, TX_PRE, TX_DATA, TX_FCS} spad_tx_t;
endpackage
`default_nettype wire

//--- rtl/spad_sync.sv
// two-stage synchroniser for pin inputs
`default_nettype none
module spad_sync #(
    parameter int W = 1
) (
    input wire logic core_clk, // core clock
    input wire logic srst, // synchronous reset
    input wire logic [W-1:0] async_in, // raw pin levels
    output logic [W-1:0] sync_out // levels in core domain
);
    logic [W-1:0] meta;

    // first stage feeds only the second
    always_ff @(posedge core_clk) begin
        if (srst) begin
            meta <= '0;
            sync_out <= '0;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule
`default_nettype wire

//--- verification/spad_phy.sv
// transceiver model: free tx clock and a receive frame sender
`default_nettype none
module spad_phy (
    output logic serial_transmit_clock, // tx clock, runs freely
    output logic serial_receive_clock, // rx clock, still between frames
    output logic serial_receive_data, // rx bit stream
    output logic serial_receive_valid // rx enable
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        serial_transmit_clock = 1'b0;
        serial_receive_clock = 1'b0;
        serial_receive_data = 1'b0;
        serial_receive_valid = 1'b0;
    end
    // tx clock is continuous, 200 ns period
    always #100 serial_transmit_clock = ~serial_transmit_clock;
    // valid high only over frame bits, lsb first
    task automatic send(input logic [7:0] b [$]);
        foreach (b[i]) for (int k = 0; k < 8; k++) begin
            serial_receive_valid = 1'b1;
            serial_receive_data = b[i][k];
            #100 serial_receive_clock = 1'b1;
            #100 serial_receive_clock = 1'b0;
        end
        serial_receive_valid = 1'b0;
        // released line must not keep looking valid
        serial_receive_data = ~serial_receive_data;
    endtask
endmodule
`default_nettype wire

//--- verification/tb_top.sv
// bench: apb traffic, two receive frames, one transmit frame
`default_nettype none
module tb_top
    import spad_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, mdio_in = 1'b0, external_reject_n = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, lo, hi;
    logic pready, pslverr, frame_byte_strobe, serial_receive_clock;
    logic serial_transmit_clock, serial_transmit_data, serial_transmit_valid;
    logic serial_receive_data, serial_receive_valid, dso, dse, dco, dce;
    logic [32:0] exp_q [$];
    logic [7:0] frm [$];
    int num_errors = 0, num_checks = 0, rises = 0, bits = 0;
    always #12.5 core_clk = ~core_clk;
    spad_phy phy (.serial_transmit_clock, .serial_receive_clock,
        .serial_receive_data, .serial_receive_valid);
    // shared pins pulled high when nobody drives them
    spad_top DUT (.core_clk, .srst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .serial_transmit_clock,
        .serial_transmit_data, .serial_transmit_valid, .serial_receive_clock,
        .serial_receive_data, .serial_receive_valid, .external_reject_n,
        .serial_collision_in(1'b0), .frame_byte_strobe,
        .decoded_rx_serial_in(dse ? dso : 1'b1), .decoded_rx_serial_out(dso),
        .decoded_rx_serial_oe(dse), .decoded_rx_clock_in(dce ? dco : 1'b1),
        .decoded_rx_clock_out(dco), .decoded_rx_clock_oe(dce),
        .nibble_rx_valid(1'b0), .nibble_rx_data(4'h0), .mdio_in);
    task automatic check(input logic [32:0] seen, input logic [32:0] want);
        num_checks++;
        if (seen !== want) begin
            num_errors++;
            $display("mismatch at %0t: %h vs %h", $time, seen, want);
        end
    endtask
    // read results come back in issue order
    always @(posedge core_clk)
        if (psel && penable && pready && !pwrite)
            check({pslverr, prdata}, exp_q.pop_front());
    always @(posedge frame_byte_strobe) rises++;
    always @(posedge serial_transmit_clock) bits += serial_transmit_valid;
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d, input logic [32:0] want);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        if (!wr) exp_q.push_back(want);
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (!pready);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // watchdog, far beyond the expected run of about 80 us
    initial begin
        #400000;
        num_errors++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(32'hBCCA));
        lo = $urandom();
        hi = {16'h0000, 16'($urandom())};
        repeat (4) @(posedge core_clk);
        srst <= 1'b0;
        apb(0, ADDR_CTRL, 0, {1'b0, CTRL_RESET});
        apb(0, 8'h1C, 0, 33'h1_0000_0000);
        apb(1, ADDR_CTRL, 32'h0000_000E, 0);
        apb(1, ADDR_STA_LO, lo, 0);
        apb(1, ADDR_STA_HI, hi, 0);
        apb(0, ADDR_STATUS, 0, 33'h0_0000_0004);
        check({dse, dce}, 2'b11);

        // first frame accepted, second refused by the outside logic
        for (int f = 0; f < 2; f++) begin
            frm = {};
            repeat (7) frm.push_back(PRE_BYTE);
            frm.push_back(SFD_BYTE);
            for (int i = 0; i < 6; i++) frm.push_back(8'({hi, lo} >> (8*i)));
            repeat (2) frm.push_back(8'($urandom()));
            external_reject_n <= (f == 0);
            rises = 0;
            phy.send(frm);
            repeat (20) @(posedge core_clk);
            // one rise at the delimiter, then one per completed byte
            check(rises, 9);
            check(frame_byte_strobe, 0);
            apb(0, ADDR_STATUS, 0, f ? 33'h804 : 33'h404);
            apb(1, ADDR_STATUS, 32'h0000_0F00, 0);
        end
        apb(0, ADDR_COUNT, 0, 33'h0_0001_0001);
        // one byte with check: 56 preamble bits, 8 delimiter, 8 data, 32 check
        apb(1, ADDR_TXDATA, 32'h0000_01A5, 0);
        wait (serial_transmit_valid);
        wait (!serial_transmit_valid);
        repeat (12) @(posedge core_clk);
        check(bits, 104);
        check(serial_transmit_data, 0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
